//--- verilog/amd_regs.vh
// Constants for the addressing-mode postbyte decoder.
// Assumes the core supplies the mode code after seeing the opcode.
// How it works
// - No-operand mode consumes no stream bytes
// - Immediate operand from stream, 8/16 bit
// - Direct byte gives address, high byte zero
// - Full address mode takes two address bytes
// - Relative signed 8/16 offset added to pc
// - Index postbyte plus zero to two extensions
// - rr0nnnnn adds signed five-bit offset to base
// - 111rr0zs: nine-bit or sixteen-bit constant offset
// - Nine-bit one extension, sixteen-bit two extensions
// - 111rr011 reads pointer at base plus offset
// - rr1pnnnn auto update by +-1..8, pre/post
// - Auto update only on x, y, stack pointer
// - 111rr1aa adds unsigned A, B or D
// - 111rr111 reads pointer at base plus D
// - Prefix byte 18 selects second opcode page
// - Accept transfer/loop postbytes alone, no extension bytes
// - Sixteen-bit base plus offset or accumulator
// - Words assembled big-endian, no alignment needed
`ifndef AMD_REGS_VH
`define AMD_REGS_VH

// Mode codes driven by the core on i_mode
`define AMD_MODE_NONE 4'h0
`define AMD_MODE_LIT8 4'h1
`define AMD_MODE_LIT16 4'h2
`define AMD_MODE_DIRECT 4'h3
`define AMD_MODE_FULL 4'h4
`define AMD_MODE_REL8 4'h5
`define AMD_MODE_REL16 4'h6
`define AMD_MODE_INDEXED 4'h7
`define AMD_MODE_POSTBYTE 4'h8

// Second page prefix
`define AMD_PAGE2_PREFIX 8'h18

// Base register field codes
`define AMD_BASE_X 2'h0
`define AMD_BASE_Y 2'h1
`define AMD_BASE_STACK 2'h2
`define AMD_BASE_PC 2'h3

// Index postbyte field positions
`define AMD_PB_BASE_HI 7
`define AMD_PB_BASE_LO 6
`define AMD_PB_FORM 5
`define AMD_PB_LONG_BASE_HI 4
`define AMD_PB_LONG_BASE_LO 3
`define AMD_PB_ACC 2
`define AMD_PB_Z 1
`define AMD_PB_S 0
`define AMD_PB_POST 4

`endif

//--- verilog/amd_postbyte_decoder.v
// Addressing-mode decoder with effective-address generation.
// Takes bytes from the instruction queue, index and accumulator values
// from the core, and reads indirect pointers over a byte-wide port.
`timescale 1ns/1ns
`default_nettype none
`include "amd_regs.vh"

module amd_postbyte_decoder (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst_n,
  // Instruction byte queue
  input wire i_byte_valid,
  input wire [7:0] i_byte,
  output wire o_byte_ready,
  // Opcode report and mode answer
  output reg o_opcode_valid,
  output reg [7:0] o_opcode,
  output reg o_page2,
  input wire i_mode_valid,
  input wire [3:0] i_mode,
  // Core registers
  input wire [15:0] i_reg_x,
  input wire [15:0] i_reg_y,
  input wire [15:0] i_reg_stack,
  input wire [15:0] i_reg_pc,
  input wire [7:0] i_acc_a,
  input wire [7:0] i_acc_b,
  // Pointer read port
  output wire o_mem_req,
  output wire [15:0] o_mem_addr,
  input wire i_mem_ack,
  input wire [7:0] i_mem_data,
  // Results
  output reg o_done,
  output reg o_ea_valid,
  output reg [15:0] o_ea,
  output reg o_operand_valid,
  output reg [15:0] o_operand,
  output reg [7:0] o_postbyte,
  output reg o_upd_we,
  output reg [1:0] o_upd_sel,
  output reg [15:0] o_upd_val
);

  localparam [6:0] S_OPC = 7'h01;
  localparam [6:0] S_MODE = 7'h02;
  localparam [6:0] S_BYTE = 7'h04;
  localparam [6:0] S_CALC = 7'h08;
  localparam [6:0] S_RDH = 7'h10;
  localparam [6:0] S_RDL = 7'h20;
  localparam [6:0] S_FIN = 7'h40;

  // Base register by field code
  function [15:0] base_of;
    input [1:0] sel;
    input [15:0] x;
    input [15:0] y;
    input [15:0] stk;
    input [15:0] pc;
    begin
      case (sel)
        `AMD_BASE_X: base_of = x;
        `AMD_BASE_Y: base_of = y;
        `AMD_BASE_STACK: base_of = stk;
        default: base_of = pc;
      endcase
    end
  endfunction

  // Extension bytes following an index postbyte
  function [1:0] tail_count;
    input [7:0] pb;
    begin
      if (!pb[`AMD_PB_FORM] || (pb[7:5] != 3'h7)) begin
        tail_count = 2'h0;
      end else if (pb[`AMD_PB_ACC]) begin
        tail_count = 2'h0;
      end else if (pb[`AMD_PB_Z]) begin
        tail_count = 2'h2;
      end else begin
        tail_count = 2'h1;
      end
    end
  endfunction

  // Pointer forms 111xx011 and 111xx111 fetch their address
  function is_indirect;
    input [7:0] pb;
    begin
      is_indirect = (pb[7:5] == 3'h7) && (pb[`AMD_PB_Z:`AMD_PB_S] == 2'h3);
    end
  endfunction

  // Carry out dropped on purpose: addresses wrap at 64K
  function [15:0] add16;
    input [15:0] a;
    input [15:0] b;
    begin
      add16 = a + b;
    end
  endfunction

  // Stream bytes that follow the mode answer
  function [1:0] mode_bytes;
    input [3:0] mode;
    begin
      case (mode)
        `AMD_MODE_LIT16, `AMD_MODE_FULL, `AMD_MODE_REL16: mode_bytes = 2'h2;
        default: mode_bytes = 2'h1;
      endcase
    end
  endfunction

  reg [6:0] state_r;
  reg [6:0] state_nxt;
  reg page_r;
  reg [3:0] mode_r;
  reg [1:0] need_r;
  reg first_r;
  reg [7:0] pb_r;
  reg [15:0] buf_r;
  reg [15:0] ptr_r;
  reg [7:0] hi_r;

  wire [15:0] acc_d = {i_acc_a, i_acc_b};
  wire long_form = (pb_r[7:5] == 3'h7);
  wire [1:0] base_sel = long_form ? pb_r[`AMD_PB_LONG_BASE_HI:`AMD_PB_LONG_BASE_LO] :
                                    pb_r[`AMD_PB_BASE_HI:`AMD_PB_BASE_LO];
  wire [15:0] base_val = base_of(base_sel, i_reg_x, i_reg_y, i_reg_stack, i_reg_pc);
  wire [15:0] auto_delta = pb_r[3] ? {{12{1'b1}}, pb_r[3:0]} :
                                     {12'h000, pb_r[3:0]} + 16'h0001;
  wire [15:0] auto_new = add16(base_val, auto_delta);

  assign o_byte_ready = (state_r == S_OPC) || (state_r == S_BYTE);
  assign o_mem_req = (state_r == S_RDH) || (state_r == S_RDL);
  // low address holds the high byte, any alignment
  // Held until ack, so a slow memory sees a steady address
  assign o_mem_addr = (state_r == S_RDL) ? add16(ptr_r, 16'h0001) : ptr_r;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_OPC: begin
        if (i_byte_valid && !(i_byte == `AMD_PAGE2_PREFIX && !page_r)) begin
          state_nxt = S_MODE;
        end
      end
      S_MODE: begin
        if (i_mode_valid) begin
          if (i_mode == `AMD_MODE_NONE) begin
            state_nxt = S_FIN;
          end else begin
            state_nxt = S_BYTE;
          end
        end
      end
      S_BYTE: begin
        if (i_byte_valid) begin
          if (first_r && mode_r == `AMD_MODE_INDEXED) begin
            state_nxt = (tail_count(i_byte) == 2'h0) ? S_CALC : S_BYTE;
          end else if (need_r == 2'h1) begin
            state_nxt = S_CALC;
          end
        end
      end
      S_CALC: begin
        if (mode_r == `AMD_MODE_INDEXED && is_indirect(pb_r)) begin
          state_nxt = S_RDH;
        end else begin
          state_nxt = S_FIN;
        end
      end
      S_RDH: begin
        if (i_mem_ack) begin
          state_nxt = S_RDL;
        end
      end
      S_RDL: begin
        if (i_mem_ack) begin
          state_nxt = S_FIN;
        end
      end
      S_FIN: begin
        state_nxt = S_OPC;
      end
      default: state_nxt = S_OPC;
    endcase
  end

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= S_OPC;
      page_r <= 1'b0;
      mode_r <= `AMD_MODE_NONE;
      need_r <= 2'h0;
      first_r <= 1'b0;
      pb_r <= 8'h00;
      buf_r <= 16'h0000;
      ptr_r <= 16'h0000;
      hi_r <= 8'h00;
      o_opcode_valid <= 1'b0;
      o_opcode <= 8'h00;
      o_page2 <= 1'b0;
      o_done <= 1'b0;
      o_ea_valid <= 1'b0;
      o_ea <= 16'h0000;
      o_operand_valid <= 1'b0;
      o_operand <= 16'h0000;
      o_postbyte <= 8'h00;
      o_upd_we <= 1'b0;
      o_upd_sel <= 2'h0;
      o_upd_val <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      o_opcode_valid <= 1'b0;
      o_done <= 1'b0;
      o_upd_we <= 1'b0;
      case (state_r)
        S_OPC: begin
          if (i_byte_valid) begin
            // prefix switches to the second page
            // A prefix after a prefix counts as the opcode
            if (i_byte == `AMD_PAGE2_PREFIX && !page_r) begin
              page_r <= 1'b1;
            end else begin
              o_opcode <= i_byte;
              o_page2 <= page_r;
              o_opcode_valid <= 1'b1;
              o_ea_valid <= 1'b0;
              o_operand_valid <= 1'b0;
            end
          end
        end
        S_MODE: begin
          if (i_mode_valid) begin
            mode_r <= i_mode;
            first_r <= 1'b1;
            buf_r <= 16'h0000;
            // size comes from the mode code
            need_r <= mode_bytes(i_mode);
          end
        end
        S_BYTE: begin
          if (i_byte_valid) begin
            first_r <= 1'b0;
            if (first_r && mode_r == `AMD_MODE_INDEXED) begin
              // postbyte sets how many extensions follow
              pb_r <= i_byte;
              need_r <= tail_count(i_byte);
            end else begin
              // earlier byte is the high byte
              buf_r <= {buf_r[7:0], i_byte};
              need_r <= need_r - 2'h1;
            end
          end
        end
        S_CALC: begin
          o_ea_valid <= 1'b1;
          case (mode_r)
            `AMD_MODE_LIT8, `AMD_MODE_LIT16: begin
              o_ea_valid <= 1'b0;
              o_operand_valid <= 1'b1;
              o_operand <= buf_r;
            end
            `AMD_MODE_POSTBYTE: begin
              o_ea_valid <= 1'b0;
              o_postbyte <= buf_r[7:0];
            end
            `AMD_MODE_DIRECT: o_ea <= {8'h00, buf_r[7:0]};
            `AMD_MODE_FULL: o_ea <= buf_r;
            `AMD_MODE_REL8: o_ea <= add16(i_reg_pc, {{8{buf_r[7]}}, buf_r[7:0]});
            `AMD_MODE_REL16: o_ea <= add16(i_reg_pc, buf_r);
            `AMD_MODE_INDEXED: begin
              o_postbyte <= pb_r;
              if (!pb_r[`AMD_PB_FORM]) begin
                o_ea <= add16(base_val, {{11{pb_r[4]}}, pb_r[4:0]});
              end else if (!long_form) begin
                // base field 11 here is a long form, so pc never updates
                // pre gives new value, post gives old
                o_ea <= pb_r[`AMD_PB_POST] ? base_val : auto_new;
                o_upd_we <= 1'b1;
                o_upd_sel <= base_sel;
                o_upd_val <= auto_new;
              end else if (!pb_r[`AMD_PB_ACC]) begin
                // nine-bit sign from s, else sixteen-bit
                if (!pb_r[`AMD_PB_Z]) begin
                  o_ea <= add16(base_val, {{8{pb_r[`AMD_PB_S]}}, buf_r[7:0]});
                end else begin
                  o_ea <= add16(base_val, buf_r);
                end
                ptr_r <= add16(base_val, buf_r);
                if (is_indirect(pb_r)) begin
                  o_ea_valid <= 1'b0;
                end
              end else begin
                case (pb_r[1:0])
                  2'h0: o_ea <= add16(base_val, {8'h00, i_acc_a});
                  2'h1: o_ea <= add16(base_val, {8'h00, i_acc_b});
                  2'h2: o_ea <= add16(base_val, acc_d);
                  default: o_ea_valid <= 1'b0;
                endcase
                ptr_r <= add16(base_val, acc_d);
              end
            end
            default: o_ea_valid <= 1'b0;
          endcase
        end
        S_RDH: begin
          if (i_mem_ack) begin
            hi_r <= i_mem_data;
          end
        end
        S_RDL: begin
          if (i_mem_ack) begin
            // same for the D indirect form
            o_ea <= {hi_r, i_mem_data};
            o_ea_valid <= 1'b1;
          end
        end
        S_FIN: begin
          o_done <= 1'b1;
          page_r <= 1'b0;
        end
        default: page_r <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- verif/amd_postbyte_props.sv
// Port checker for the postbyte decoder.
// Assumes it is bound onto amd_postbyte_decoder.
`timescale 1ns/1ns
`default_nettype none
module amd_postbyte_props (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Watched ports
  input wire logic o_byte_ready,
  input wire logic o_opcode_valid,
  input wire logic o_done,
  input wire logic o_ea_valid,
  input wire logic o_upd_we,
  input wire logic [1:0] o_upd_sel,
  input wire logic o_mem_req,
  input wire logic [15:0] o_mem_addr,
  input wire logic i_mem_ack
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Second read of a pointer pair
  logic half_r;
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      half_r <= 1'b0;
    else if (o_mem_req && i_mem_ack)
      half_r <= ~half_r;
  end
  sequence s_hi_read;
    o_mem_req && i_mem_ack && !half_r;
  endsequence
  sequence s_lo_read;
    o_mem_req && i_mem_ack && half_r;
  endsequence
  refuse_mode_wait_a: assert property (o_opcode_valid |-> !o_byte_ready)
    else $error("byte ready in mode wait");
  upd_base_legal_a: assert property (o_upd_we |-> o_upd_sel != 2'h3)
    else $error("update names pc");
  upd_with_ea_a: assert property (o_upd_we |-> o_ea_valid)
    else $error("update without address");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done longer than a cycle");
  op_done_bound_a: assert property (o_opcode_valid |-> ##[1:40] o_done)
    else $error("decode never finished");
  ptr_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("pointer read dropped");
  ptr_next_a: assert property (s_hi_read |=> o_mem_req && o_mem_addr == $past(o_mem_addr) + 16'h0001)
    else $error("low byte not at next address");
  ptr_two_reads_a: assert property (s_lo_read |=> !o_mem_req)
    else $error("extra pointer read");
endmodule
bind amd_postbyte_decoder amd_postbyte_props u_props (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .o_byte_ready(o_byte_ready), .o_opcode_valid(o_opcode_valid),
  .o_done(o_done), .o_ea_valid(o_ea_valid), .o_upd_we(o_upd_we), .o_upd_sel(o_upd_sel),
  .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack));
`default_nettype wire

//--- verif/amd_ptr_mem_model.sv
// Byte memory answering pointer reads.
// Assumes one request level; acks at once, or on the fourth cycle of a request when i_slow is set.
`timescale 1ns/1ns
`default_nettype none
module amd_ptr_mem_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control and read port
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic [15:0] i_addr,
  output logic o_ack,
  output logic [7:0] o_data
);
  logic [1:0] cnt_r;
  logic [7:0] last_r;
  assign o_ack = i_req && (!i_slow || cnt_r == 2'h3);
  // Stale data inverted so it never looks valid
  assign o_data = o_ack ? (i_addr[7:0] ^ 8'h3C) : ~last_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 2'h0;
      last_r <= 8'h00;
    end else begin
      cnt_r <= (i_req && !o_ack) ? cnt_r + 2'h1 : 2'h0;
      if (o_ack)
        last_r <= o_data;
    end
  end
endmodule
`default_nettype wire

//--- verif/amd_tb.sv
// Self-checking bench for the postbyte decoder.
// Assumes the mode answer handshake of the decoder.
`timescale 1ns/1ns
`default_nettype none
`include "amd_regs.vh"
module testbench;
  logic clk, i_rst_n, i_byte_valid, i_mode_valid, slow;
  logic [7:0] i_byte;
  logic [3:0] i_mode;
  logic [7:0] acc_a;
  wire rdy, opv, pg2, req, ack, done, eav, opnv, upd_we;
  wire [7:0] opc, mdat, pb;
  wire [15:0] addr, ea, opn, upd_val;
  wire [1:0] upd_sel;
  logic [15:0] upd_v;
  logic [1:0] upd_s;
  int bad_count = 0;
  int num_checks = 0;
  int n_upd = 0;
  amd_postbyte_decoder DUT (.i_core_clk(clk), .i_rst_n(i_rst_n), .i_byte_valid(i_byte_valid),
    .i_byte(i_byte), .o_byte_ready(rdy), .o_opcode_valid(opv), .o_opcode(opc), .o_page2(pg2),
    .i_mode_valid(i_mode_valid), .i_mode(i_mode), .i_reg_x(16'h1000), .i_reg_y(16'h2000),
    .i_reg_stack(16'h3000), .i_reg_pc(16'h4000), .i_acc_a(acc_a), .i_acc_b(8'h0F),
    .o_mem_req(req), .o_mem_addr(addr), .i_mem_ack(ack), .i_mem_data(mdat), .o_done(done),
    .o_ea_valid(eav), .o_ea(ea), .o_operand_valid(opnv), .o_operand(opn), .o_postbyte(pb),
    .o_upd_we(upd_we), .o_upd_sel(upd_sel), .o_upd_val(upd_val));
  amd_ptr_mem_model u_mem (.i_clk(clk), .i_rst_n(i_rst_n), .i_slow(slow), .i_req(req),
    .i_addr(addr), .o_ack(ack), .o_data(mdat));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (upd_we === 1'b1) begin
      upd_v <= upd_val;
      upd_s <= upd_sel;
      n_upd <= n_upd + 1;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task put(input logic [7:0] b);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 50) begin
      i_byte_valid = 0;
      @(negedge clk);
      n++;
    end
    i_byte_valid = 1;
    i_byte = b;
    @(negedge clk);
  endtask
  task op(input logic pre, input logic [7:0] opb, input logic [3:0] m, input int n,
          input logic [23:0] bs);
    int k;
    if (pre)
      put(`AMD_PAGE2_PREFIX);
    put(opb);
    i_byte_valid = 0;
    k = 0;
    while (opv !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    i_mode_valid = 1;
    i_mode = m;
    @(negedge clk);
    i_mode_valid = 0;
    for (k = 0; k < n; k++)
      put(bs[23 - 8 * k -: 8]);
    i_byte_valid = 0;
    k = 0;
    while (done !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    chk(done, 16'h1);
  endtask
  task t_plain;
    op(0, 8'h12, `AMD_MODE_NONE, 0, 0);
    chk({eav, opnv}, 16'h0);
    op(0, 8'h86, `AMD_MODE_LIT8, 1, 24'h9C0000);
    chk(opn, 16'h009C);
    chk({eav, opnv}, 16'h1);
    op(0, 8'hCC, `AMD_MODE_LIT16, 2, 24'h123400);
    chk(opn, 16'h1234);
    op(0, 8'h96, `AMD_MODE_DIRECT, 1, 24'h800000);
    chk(ea, 16'h0080);
    op(0, 8'hB6, `AMD_MODE_FULL, 2, 24'hABCD00);
    chk(ea, 16'hABCD);
    op(0, 8'h20, `AMD_MODE_REL8, 1, 24'h800000);
    chk(ea, 16'h3F80);
    op(1, 8'h20, `AMD_MODE_REL16, 2, 24'h800000);
    chk({pg2, opc}, 16'h0120);
    chk(ea, 16'hC000);
    op(0, 8'hB7, `AMD_MODE_POSTBYTE, 1, 24'hB70000);
    chk({pg2, pb}, 16'h00B7);
  endtask
  task t_const;
    op(0, 8'hA6, `AMD_MODE_INDEXED, 1, 24'hD00000);
    chk(ea, 16'h3FF0);
    op(0, 8'hA6, `AMD_MODE_INDEXED, 1, 24'h0F0000);
    chk(ea, 16'h100F);
    op(0, 8'hA6, `AMD_MODE_INDEXED, 2, 24'hE90000);
    chk(ea, 16'h1F00);
    op(0, 8'hA6, `AMD_MODE_INDEXED, 2, 24'hE0FF00);
    chk(ea, 16'h10FF);
    op(0, 8'hA6, `AMD_MODE_INDEXED, 3, 24'hF2F000);
    chk(ea, 16'h2000);
    op(0, 8'hA6, `AMD_MODE_INDEXED, 1, 24'hE40000);
    chk(ea, 16'h10F0);
    op(0, 8'hA6, `AMD_MODE_INDEXED, 1, 24'hED0000);
    chk(ea, 16'h200F);
    op(0, 8'hA6, `AMD_MODE_INDEXED, 1, 24'hFE0000);
    chk(ea, 16'h300F);
    acc_a = 8'h80;
    op(0, 8'hA6, `AMD_MODE_INDEXED, 1, 24'hE40000);
    chk(ea, 16'h1080);
    acc_a = 8'hF0;
  endtask
  task t_auto;
    op(0, 8'hA6, `AMD_MODE_INDEXED, 1, 24'hA80000);
    chk({upd_s, ea}, 18'h22FF8);
    op(0, 8'hA6, `AMD_MODE_INDEXED, 1, 24'h770000);
    chk({ea, upd_v}, 32'h20002008);
    op(0, 8'hA6, `AMD_MODE_INDEXED, 1, 24'h200000);
    chk({upd_s, upd_v}, 18'h01001);
    chk(n_upd, 16'h3);
  endtask
  task t_indirect;
    op(0, 8'hA6, `AMD_MODE_INDEXED, 3, 24'hE30100);
    chk(ea, 16'h3C3D);
    chk({eav, opnv}, 16'h2);
    slow = 1;
    op(0, 8'hA6, `AMD_MODE_INDEXED, 1, 24'hEF0000);
    chk(ea, 16'h332C);
    chk({eav, opnv}, 16'h2);
    slow = 0;
  endtask
  task tally_and_finish;
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    i_rst_n = 0;
    i_byte_valid = 0;
    i_byte = 0;
    i_mode_valid = 0;
    i_mode = 0;
    slow = 0;
    acc_a = 8'hF0;
    repeat (3) @(negedge clk);
    i_rst_n = 1;
    t_plain;
    t_const;
    t_auto;
    t_indirect;
    tally_and_finish;
  end
  initial begin
    #40000;
    bad_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
